/* File: sem_pkg.sv */
// Purpose: Shared constants for the semaphore-port controller.
// Assumes: One port of a 16-bit dual-port RAM with eight token flags.
// Notes:   Cycle counts derive from times at a 100 MHz core clock.
package sem_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned STROBE_NS     = 30;   // Least strobe and access time
   localparam int unsigned STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GAP_NS        = 20;   // Least idle between cycles
   localparam int unsigned GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned FLAG_SEL_W    = 3;
   localparam int unsigned ADDR_W        = 14;
   localparam int unsigned CNT_W         = 4;
   localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
   localparam logic [CNT_W-1:0] GAP_CNT    = CNT_W'(GAP_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 14'h0000;
   localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_ONES = 16'hFFFF;
endpackage

/* File: sem_cycle_if.sv */
// Purpose: Carries one bus-cycle request between controller and cycle engine.
// Assumes: Same clock on both sides.
// Notes:   A request is held until done pulses.
`timescale 1ns/1ps
interface sem_cycle_if;
   logic                          start;
   logic                          write;
   logic                          wdata;
   logic [sem_pkg::FLAG_SEL_W-1:0] sel;
   logic                          done;
   logic [sem_pkg::DATA_W-1:0]    rdata;
   modport ctrl   (output start, output write, output wdata, output sel,
                   input done, input rdata);
   modport engine (input start, input write, input wdata, input sel,
                   output done, output rdata);
endinterface

/* File: sem_cycle_engine.sv */
// Purpose: Runs one static-RAM style cycle on the semaphore space.
// Assumes: Pin inputs synchronised by the caller.
// Notes:   Each request opens with select and strobe asserted together.
`timescale 1ns/1ps
module sem_cycle_engine (
   input  wire logic                       core_clk,
   input  wire logic                       resetn,
   input  wire logic                       clk_en,
   sem_cycle_if.engine                     cyc,
   input  wire logic [sem_pkg::DATA_W-1:0] data_sync,
   output logic                            sem_n,
   output logic                            oe_n,
   output logic                            we_n,
   output logic [sem_pkg::FLAG_SEL_W-1:0]  sel_o,
   output logic                            d0_out,
   output logic                            d0_oe
);
   typedef enum logic [1:0] {E_IDLE, E_STROBE, E_GAP} estate_t;
   typedef struct packed {
      estate_t                         st;
      logic [sem_pkg::CNT_W-1:0]       cnt;
      logic                            sem_n;
      logic                            oe_n;
      logic                            we_n;
      logic [sem_pkg::FLAG_SEL_W-1:0]  sel;
      logic                            d0;
      logic                            d0_oe;
      logic                            done;
      logic [sem_pkg::DATA_W-1:0]      rdata;
   } eng_t;
   eng_t s_q, s_d;

   // Cycle sequencing; strobes drop together so the read latch releases
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         E_IDLE: begin
            if (cyc.start && !s_q.done) begin
               s_d.st    = E_STROBE;
               s_d.cnt   = sem_pkg::STROBE_CNT;
               s_d.sem_n = 1'b0;             // R3
               s_d.sel   = cyc.sel;
               s_d.oe_n  = cyc.write;
               s_d.we_n  = !cyc.write;
               s_d.d0    = cyc.wdata;
               s_d.d0_oe = cyc.write;
            end
         end
         E_STROBE: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (s_q.cnt == 4'h1) begin
               s_d.st    = E_GAP;
               s_d.cnt   = sem_pkg::GAP_CNT;
               s_d.sem_n = 1'b1;
               s_d.oe_n  = 1'b1;
               s_d.we_n  = 1'b1;
               s_d.d0_oe = 1'b0;
               s_d.rdata = data_sync;
            end
         end
         E_GAP: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (s_q.cnt == 4'h1) begin
               s_d.st   = E_IDLE;
               s_d.done = 1'b1;
            end
         end
         default: s_d.st = E_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '{st: E_IDLE, cnt: sem_pkg::CNT_ZERO, sem_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  sel: 3'h0, d0: 1'b1, d0_oe: 1'b0, done: 1'b0,
                  rdata: sem_pkg::DATA_RST};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign sem_n     = s_q.sem_n;
   assign oe_n      = s_q.oe_n;
   assign we_n      = s_q.we_n;
   assign sel_o     = s_q.sel;
   assign d0_out    = s_q.d0;
   assign d0_oe     = s_q.d0_oe;
   assign cyc.done  = s_q.done;
   assign cyc.rdata = s_q.rdata;

   // Select and write strobe never overlap a driven-off data line
   write_drive_a: assert property (@(posedge core_clk) disable iff (!resetn) // R3
      !we_n |-> (d0_oe && !sem_n)) else $error("write strobe without data drive");
   strobe_len_a: assert property (@(posedge core_clk) disable iff (!resetn) // R3
      $fell(sem_n) |-> !sem_n [*3]) else $error("semaphore strobe too short");
endmodule

/* File: sem_host.sv */
// Purpose: Host controller that claims and frees token flags on one port.
// Assumes: The far device holds eight active-low flags per port.
// Notes:   Claim runs write-zero then read-back; a loss withdraws.
// Operation
// [R1] The device keeps eight flag latches apart from its memory array.
// [R2] Flags are active low: write zero to claim, write one to release.
// [R3] Token space is chosen by a low select; strobes act as in SRAM cycles.
// [R4] Only the three low address bits pick the flag.
// [R5] A flag write uses only the lowest data line.
// [R6] A zero written to a free flag reads zero here and one on the far side.
// [R7] The owner writing one frees the flag unless the far side is pending.
// [R8] A losing zero stays pending while that side reads one.
// [R9] A pending request takes the token as soon as the owner frees it.
// [R10] A flag read shows its value on all data bits.
// [R11] The read value is latched until select or output enable drops.
// [R12] A requester writes zero first, then reads back to confirm.
// [R13] Racing requests give the token to exactly one side.
// [R14] A failed request is followed by polling reads or a withdrawing one.
// [R15] Software writes one to every flag on both sides at start-up.
// [R16] Flags are written on the lowest data line and read on all sixteen.
// [R17] The array chip enable stays off in every token-space cycle.
`timescale 1ns/1ps
module sem_host (
   input  wire logic                          core_clk,
   input  wire logic                          resetn,
   input  wire logic                          clk_en,
   input  wire logic                          init_req,
   input  wire logic                          claim_req,
   input  wire logic                          free_req,
   input  wire logic [sem_pkg::FLAG_SEL_W-1:0] flag_id,
   output logic                               busy,
   output logic                               op_done,
   output logic                               op_won,
   output logic [7:0]                         owned,
   input  wire logic [sem_pkg::DATA_W-1:0]    data_in,
   output logic [sem_pkg::DATA_W-1:0]         data_out,
   output logic [sem_pkg::DATA_W-1:0]         data_oe,
   output logic [sem_pkg::ADDR_W-1:0]         addr,
   output logic                               token_space_select_n,
   output logic                               array_ce_n,
   output logic                               oe_n,
   output logic                               we_n
);
   typedef enum logic [2:0] {H_IDLE, H_INIT, H_WR0, H_RD, H_WITHDRAW, H_FREE} hstate_t;
   typedef struct packed {
      hstate_t                         st;
      logic [sem_pkg::FLAG_SEL_W-1:0]  flag;
      logic                            start;
      logic                            write;
      logic                            wdata;
      logic                            busy;
      logic                            done;
      logic                            won;
      logic [7:0]                      owned;
   } host_t;
   host_t h_q, h_d;

   sem_cycle_if cyc ();
   logic [sem_pkg::DATA_W-1:0] din_meta_q;
   logic [sem_pkg::DATA_W-1:0] din_sync_q;
   logic                        sem_n_w, oe_n_w, we_n_w, d0_w, d0_oe_w;
   logic [sem_pkg::FLAG_SEL_W-1:0] sel_w;

   // Two-stage synchroniser on the data pins
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         din_meta_q <= sem_pkg::DATA_RST;
         din_sync_q <= sem_pkg::DATA_RST;
      end else if (clk_en) begin
         din_meta_q <= data_in;
         din_sync_q <= din_meta_q;
      end
   end

   sem_cycle_engine u_eng (
      .core_clk (core_clk),
      .resetn   (resetn),
      .clk_en   (clk_en),
      .cyc      (cyc.engine),
      .data_sync(din_sync_q),
      .sem_n    (sem_n_w),
      .oe_n     (oe_n_w),
      .we_n     (we_n_w),
      .sel_o    (sel_w),
      .d0_out   (d0_w),
      .d0_oe    (d0_oe_w)
   );

   assign cyc.start = h_q.start;
   assign cyc.write = h_q.write;
   assign cyc.wdata = h_q.wdata;
   assign cyc.sel   = h_q.flag;

   // Command sequencing; each step waits for its cycle to finish
   always_comb begin
      h_d = h_q;
      h_d.done = 1'b0;
      case (h_q.st)
         H_IDLE: begin
            h_d.busy = 1'b0;
            if (init_req) begin
               h_d = '{st: H_INIT, flag: 3'h0, start: 1'b1, write: 1'b1,
                       wdata: 1'b1, busy: 1'b1, done: 1'b0, won: 1'b0,
                       owned: 8'h00};         // R15
            end else if (claim_req) begin
               h_d.st = H_WR0; h_d.flag = flag_id; h_d.start = 1'b1;
               h_d.write = 1'b1; h_d.wdata = 1'b0; h_d.busy = 1'b1; // R12 R2
            end else if (free_req) begin
               h_d.st = H_FREE; h_d.flag = flag_id; h_d.start = 1'b1;
               h_d.write = 1'b1; h_d.wdata = 1'b1; h_d.busy = 1'b1; // R2
            end
         end
         H_INIT: begin
            if (cyc.done) begin
               if (h_q.flag == 3'h7) begin
                  h_d.st = H_IDLE; h_d.start = 1'b0; h_d.done = 1'b1; h_d.won = 1'b0;
               end else begin
                  h_d.flag = h_q.flag + 3'h1;
               end
            end
         end
         H_WR0: begin
            if (cyc.done) begin
               h_d.st = H_RD; h_d.write = 1'b0;   // R12
            end
         end
         H_RD: begin
            if (cyc.done) begin
               // Only a full zero word is the win; any high bit counts as a loss
               if (cyc.rdata == sem_pkg::DATA_RST) begin   // R10 R6
                  h_d.st = H_IDLE; h_d.start = 1'b0; h_d.done = 1'b1; h_d.won = 1'b1;
                  h_d.owned[h_q.flag] = 1'b1;
               end else begin
                  // Withdraw so a stale request cannot seize the token later
                  h_d.st = H_WITHDRAW; h_d.write = 1'b1; h_d.wdata = 1'b1; // R14 R8
               end
            end
         end
         H_WITHDRAW, H_FREE: begin
            if (cyc.done) begin
               h_d.st = H_IDLE; h_d.start = 1'b0; h_d.done = 1'b1;
               h_d.won = 1'b0;
               h_d.owned[h_q.flag] = 1'b0;       // R7
            end
         end
         default: h_d.st = H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         h_q <= '{st: H_IDLE, flag: 3'h0, start: 1'b0, write: 1'b0,
                  wdata: 1'b1, busy: 1'b0, done: 1'b0, won: 1'b0, owned: 8'h00};
      end else if (clk_en) begin
         h_q <= h_d;
      end
   end

   assign busy    = h_q.busy;
   assign op_done = h_q.done;
   assign op_won  = h_q.won;
   assign owned   = h_q.owned;

   // Pin drive: engine flops feed pins directly; upper address lines held low
   assign token_space_select_n = sem_n_w;
   assign array_ce_n           = 1'b1;                             // R17
   assign oe_n                 = oe_n_w;
   assign we_n                 = we_n_w;
   assign addr     = {{(sem_pkg::ADDR_W-sem_pkg::FLAG_SEL_W){1'b0}}, sel_w};  // R4
   assign data_out = {{(sem_pkg::DATA_W-1){1'b0}}, d0_w};                  // R5 R16
   assign data_oe  = {{(sem_pkg::DATA_W-1){1'b0}}, d0_oe_w};

   // A claim always writes zero before its read-back
   claim_order_a: assert property (@(posedge core_clk) disable iff (!resetn) // R12
      (h_q.st == H_WR0) |-> (h_q.write && !h_q.wdata))
      else $error("claim not write-zero");

   // Read-back only after the write cycle finished; reading first invites a race
   claim_then_read_a: assert property (@(posedge core_clk) disable iff (!resetn) // R12
      (h_q.st == H_WR0 && cyc.done && clk_en) |=> (h_q.st == H_RD && !h_q.write))
      else $error("read-back not after write");

   // A lost claim goes straight to its withdraw
   loss_withdraw_a: assert property (@(posedge core_clk) disable iff (!resetn) // R14
      (h_q.st == H_RD && cyc.done && cyc.rdata != sem_pkg::DATA_RST && clk_en)
      |=> (h_q.st == H_WITHDRAW))
      else $error("lost claim not withdrawn");

   // Withdraw must write one, or the stale request could grab the token later
   withdraw_one_a: assert property (@(posedge core_clk) disable iff (!resetn) // R14
      (h_q.st == H_WITHDRAW && !we_n) |-> data_out[0])
      else $error("withdraw wrote zero");

   // A lost claim never reports the flag as held
   lost_not_owned_a: assert property (@(posedge core_clk) disable iff (!resetn) // R14
      (op_done && !op_won) |-> !owned[h_q.flag])
      else $error("lost flag marked owned");

   // A won claim is recorded in the ownership map
   win_owned_a: assert property (@(posedge core_clk) disable iff (!resetn) // R12
      (op_done && op_won) |-> owned[h_q.flag])
      else $error("won flag not marked owned");

   // The array stays deselected in every token-space cycle
   ce_off_a: assert property (@(posedge core_clk) disable iff (!resetn) // R17
      !token_space_select_n |-> array_ce_n)
      else $error("array enabled in token cycle");

   // Free writes one on the data line
   free_one_a: assert property (@(posedge core_clk) disable iff (!resetn) // R2
      (h_q.st == H_FREE && !we_n) |-> data_out[0])
      else $error("free wrote zero");

   // Start-up clearing writes one to each flag
   init_ones_a: assert property (@(posedge core_clk) disable iff (!resetn) // R15
      (h_q.st == H_INIT && !we_n) |-> data_out[0])
      else $error("init wrote zero");

   // Start-up clearing steps through the flags one at a time
   init_walk_a: assert property (@(posedge core_clk) disable iff (!resetn) // R15
      (h_q.st == H_INIT && cyc.done && clk_en && h_q.flag != 3'h7)
      |=> (h_q.flag == $past(h_q.flag) + 3'h1))
      else $error("init skipped a flag");

   // Read and write strobes never overlap
   strobe_excl_a: assert property (@(posedge core_clk) disable iff (!resetn) // R3
      !oe_n |-> we_n)
      else $error("read and write strobes together");

   // Strobes only act inside a token-space select
   strobe_select_a: assert property (@(posedge core_clk) disable iff (!resetn) // R3
      (!oe_n || !we_n) |-> !token_space_select_n)
      else $error("strobe without token select");

   // Upper address lines stay low in token cycles
   addr_upper_a: assert property (@(posedge core_clk) disable iff (!resetn) // R4
      !token_space_select_n |-> (addr[13:3] == 11'h000))
      else $error("upper address set in token cycle");
endmodule

/* File: sem_dev_model.sv */
// Purpose: Behavioural two-port token-flag device facing the host controller.
// Assumes: Strobes are held for several ns; writes and reads act 1 ns after strobes meet.
// Notes:   Power-up flags are scrambled on purpose; unselected pins show inverse data.
`timescale 1ns/1ps
module sem_dev_model (
   input  wire logic        sem_n_l,
   input  wire logic        oe_n_l,
   input  wire logic        we_n_l,
   input  wire logic [13:0] addr_l,
   input  wire logic        d0_l,
   output logic      [15:0] rd_l,
   input  wire logic        sem_n_r,
   input  wire logic        oe_n_r,
   input  wire logic        we_n_r,
   input  wire logic [13:0] addr_r,
   input  wire logic        d0_r,
   output logic      [15:0] rd_r
);
   // Eight request latches per side and the owner of each flag, apart from any array
   logic [7:0]  req_l = 8'hA5;
   logic [7:0]  req_r = 8'h3C;
   logic [7:0]  own_l = 8'h5A;
   logic [7:0]  own_r = 8'h81;
   logic [15:0] lat_l = 16'hFFFF;
   logic [15:0] lat_r = 16'hFFFF;

   // A write reaches only its own side's latch; first zero presented wins
   task automatic put(input bit right, input logic [2:0] f, input logic v);
      if (right) req_r[f] = v;
      else req_l[f] = v;
      if (own_l[f] && req_l[f]) own_l[f] = 1'h0;
      if (own_r[f] && req_r[f]) own_r[f] = 1'h0;
      if (!own_l[f] && !own_r[f] && !req_l[f]) own_l[f] = 1'h1;
      else if (!own_l[f] && !own_r[f] && !req_r[f]) own_r[f] = 1'h1;
   endtask

   // Writes act while select and write strobe are both low
   always @(posedge (!sem_n_l && !we_n_l)) begin
      #1;
      put(1'b0, addr_l[2:0], d0_l);
   end
   always @(posedge (!sem_n_r && !we_n_r)) begin
      #1;
      put(1'b1, addr_r[2:0], d0_r);
   end

   // Read value frozen at select plus enable, so a far write cannot tear it
   always @(posedge (!sem_n_l && !oe_n_l)) begin
      #1;
      lat_l = {16{!own_l[addr_l[2:0]]}};
   end
   always @(posedge (!sem_n_r && !oe_n_r)) begin
      #1;
      lat_r = {16{!own_r[addr_r[2:0]]}};
   end
   assign rd_l = (!sem_n_l && !oe_n_l) ? lat_l : ~lat_l;
   assign rd_r = (!sem_n_r && !oe_n_r) ? lat_r : ~lat_r;
endmodule

/* File: dual_port_semaphore_flags_tb.sv */
// Purpose: Self-checking bench for the token-flag host controller.
// Assumes: The bench plays the far-side processor on the model's right port.
// Notes:   Random flags and random upper address bits; the seed is fixed.
`timescale 1ns/1ps
module dual_port_semaphore_flags_tb;
   logic        core_clk, resetn, clk_en, init_req, claim_req, free_req, busy, op_done, op_won;
   logic [2:0]  flag_id, f;
   logic [7:0]  owned;
   logic [15:0] data_in, data_out, data_oe, rd_l, rd_r, q;
   logic [13:0] addr, addr_r;
   logic        token_space_select_n, array_ce_n, oe_n, we_n, sem_n_r, oe_n_r, we_n_r, d0_r;
   int          bad_count = 0;
   int          checks_done = 0;
   logic        hold_en = 1'h0;

   sem_host i_sem_host (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .init_req(init_req), .claim_req(claim_req), .free_req(free_req), .flag_id(flag_id),
      .busy(busy), .op_done(op_done), .op_won(op_won), .owned(owned), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .addr(addr),
      .token_space_select_n(token_space_select_n), .array_ce_n(array_ce_n), .oe_n(oe_n),
      .we_n(we_n));
   sem_dev_model i_sem_dev_model (.sem_n_l(token_space_select_n), .oe_n_l(oe_n), .we_n_l(we_n),
      .addr_l(addr), .d0_l(data_in[0]), .rd_l(rd_l), .sem_n_r(sem_n_r), .oe_n_r(oe_n_r),
      .we_n_r(we_n_r), .addr_r(addr_r), .d0_r(d0_r), .rd_r(rd_r));
   // Wire level: the host drives where enabled, the device elsewhere
   assign data_in = (data_oe & data_out) | (~data_oe & rd_l);

   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask

   // Word the far side should read: all zeros when it holds the flag
   function automatic logic [15:0] flag_word(input bit held);
      return held ? 16'h0000 : 16'hFFFF;
   endfunction

   // Host request; a stray free while busy must be ignored
   task automatic host_op(input int kind, input logic [2:0] fl);
      int n;
      logic [15:0] snap;
      logic [15:0] cur;
      n = 0;
      flag_id = fl;
      init_req = (kind == 0);
      claim_req = (kind == 1);
      free_req = (kind == 2);
      @(posedge core_clk);
      #1;
      init_req = 1'h0;
      claim_req = 1'h0;
      free_req = 1'h1;
      check(16'(busy), 16'h0001, "busy not raised");
      while (op_done !== 1'h1 && n < 400) begin
         @(posedge core_clk);
         #1;
         free_req = 1'h0;
         n++;
         // Freeze mid-strobe: pins and status must not move while disabled
         if (hold_en && n == 3) begin
            snap = 16'({token_space_select_n, oe_n, we_n, busy, owned, addr[2:0]});
            clk_en = 1'h0;
            repeat (4) @(posedge core_clk);
            #1;
            cur = 16'({token_space_select_n, oe_n, we_n, busy, owned, addr[2:0]});
            check(cur, snap, "state moved while disabled");
            clk_en = 1'h1;
         end
      end
      if (n >= 400) check(16'h0000, 16'h0001, "no completion");
   endtask

   // Far-side cycle of four clocks, strobe held for three; high address bits are noise
   task automatic r_cyc(input logic [2:0] fl, input logic wr, input logic v);
      addr_r = {11'($urandom), fl};
      d0_r = v;
      sem_n_r = 1'h0;
      we_n_r = !wr;
      oe_n_r = wr;
      repeat (3) @(posedge core_clk);
      #1;
      q = rd_r;
      sem_n_r = 1'h1;
      we_n_r = 1'h1;
      oe_n_r = 1'h1;
      @(posedge core_clk);
      #1;
   endtask

   // Pin checks on every token-space cycle
   always @(negedge core_clk) begin
      if (resetn && token_space_select_n === 1'h0) begin
         check(16'(array_ce_n), 16'h0001, "array enabled");
         check(16'(addr[13:3]), 16'h0000, "upper address set");
         if (data_oe[0] === 1'h1) check(data_out[15:1], 15'h0000, "upper data driven");
      end
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      $display("CHECK FAILED at %0t: run too long", $time);
      test_done;
   end

   initial begin
      {clk_en, init_req, claim_req, free_req, flag_id, resetn} = 8'h80;
      {sem_n_r, oe_n_r, we_n_r, d0_r, addr_r} = 18'h3C000;
      void'($urandom(32'hC08D));
      repeat (8) @(posedge core_clk);
      #1;
      resetn = 1'h1;
      check({token_space_select_n, oe_n, we_n, busy, owned}, 12'hE00, "reset state");
      check(data_oe, 16'h0000, "reset drive");
      host_op(0, 3'h0);
      for (int i = 0; i < 8; i++) r_cyc(3'(i), 1'h1, 1'h1);
      check(16'(owned), 16'h0000, "flags after init");
      $display("test init done");
      for (int t = 0; t < 8; t++) begin
         // Both end flags first as corner cases, then random ones
         f = (t == 0) ? 3'h7 : ((t == 1) ? 3'h0 : 3'($urandom));
         hold_en = (t == 3);
         host_op(1, f);
         hold_en = 1'h0;
         check(16'({op_won, owned[f]}), 16'h0003, "claim of free flag");
         r_cyc(f, 1'h0, 1'h0);
         check(q, flag_word(0), "far read of held flag");
         r_cyc(f, 1'h1, 1'h0);
         r_cyc(f, 1'h0, 1'h0);
         check(q, flag_word(0), "pending far request");
         host_op(2, f);
         check(16'(owned[f]), 16'h0000, "free");
         r_cyc(f, 1'h0, 1'h0);
         check(q, flag_word(1), "handover to far side");
         host_op(1, f);
         check(16'({op_won, owned[f]}), 16'h0000, "claim of held flag");
         // A missing withdraw would hand the flag to the host here
         r_cyc(f, 1'h1, 1'h1);
         r_cyc(f, 1'h1, 1'h0);
         r_cyc(f, 1'h0, 1'h0);
         check(q, flag_word(1), "flag free after withdraw");
         r_cyc(f, 1'h1, 1'h1);
         host_op(2, f);
         $display("test round %0d done", t);
      end
      test_done;
   end
endmodule
